// *** hw/bba_core.sv ***
// Operation
// RQ1: immediate sum adds literal to accumulator, result to accumulator, updates carry, nibble, zero.
// RQ2: register sum adds accumulator and file register; destination select picks accumulator or register.
// RQ3: immediate mask ANDs accumulator with literal into accumulator; only zero changes.
// RQ4: register mask ANDs accumulator with file register; destination select picks target; only zero.
// RQ5: bit clear zeroes one selected bit of a file register; flags untouched.
// RQ6: bit set forces one selected bit of a file register high; flags untouched.
// RQ7: skip-if-low discards the next instruction when the tested bit is zero.
// RQ8: skip-if-high discards the next instruction when the tested bit is one.
// RQ9: every operation takes one cycle; a met skip adds one squash cycle.
// RQ10: carry from bit 7, nibble carry from bit 3, zero when result is zero.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module bba_core #(
  parameter int FILE_DEPTH = 128
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic opValid,
  input wire bba_pkg::bba_instr_s instr,
  output logic opReady,
  output logic opDone,
  output logic [bba_pkg::DATA_W-1:0] accOut,
  output bba_pkg::bba_flags_s statusOut,
  output logic skipSquash,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int AW = bba_pkg::FILE_ADDR_W;
  localparam int DW = bba_pkg::DATA_W;

  if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << AW)) begin : g_depth_check
    $error("bba_core: file depth does not fit the address field");
  end

  bba_pkg::bba_core_state_s st_reg;
  bba_pkg::bba_core_state_s st_next;
  logic [DW-1:0] fileMem [FILE_DEPTH];

  logic [DW-1:0] fileRd;
  logic [DW-1:0] bitHot;
  logic bitVal;
  logic [DW-1:0] addB;
  logic [DW-1:0] sumRes;
  logic sumCarry;
  logic sumNibble;
  logic [DW-1:0] maskRes;
  logic accept;
  logic fire;
  logic squashing;
  logic memWe;
  logic [AW-1:0] memAddr;
  logic [DW-1:0] memData;
  logic [11:0] localAddr;
  logic highZero;
  logic inWin;
  logic [AW-1:0] winIdx;
  logic apbAccess;
  logic apbCommit;
  logic mapped;
  logic [31:0] rdWord;

  bba_adder #(
    .W(DW),
    .NIB(bba_pkg::NIB_W)
  ) u_adder (
    .a(st_reg.acc),
    .b(addB),
    .sum(sumRes),
    .carryOut(sumCarry),
    .nibbleOut(sumNibble)
  );

  bba_bitmask #(
    .W(DW),
    .SEL_W(bba_pkg::BIT_SEL_W)
  ) u_bitmask (
    .sel(instr.bitSel),
    .mask(bitHot)
  );

  assign fileRd = fileMem[instr.fileAddr];
  assign bitVal = |(fileRd & bitHot);
  assign addB = (instr.op == bba_pkg::SUM_REGISTER_OP) ? fileRd : instr.literal;
  assign maskRes = (instr.op == bba_pkg::MASK_REGISTER_OP) ? (st_reg.acc & fileRd) : (st_reg.acc & instr.literal);
  assign accept = opValid & st_reg.opReady;
  assign squashing = (st_reg.state == bba_pkg::ST_SQUASH);
  assign fire = accept & ~squashing;

  assign localAddr = paddr[11:0];
  assign highZero = (paddr[31:12] == bba_pkg::HIGH_ADDR_ZERO);
  assign inWin = highZero & (localAddr[11:9] == bba_pkg::FILE_WIN_SEL);
  assign winIdx = localAddr[AW+1:2];
  assign apbAccess = psel & penable & ~st_reg.pready;
  assign apbCommit = psel & penable & st_reg.pready & pwrite & ~st_reg.pslverr;

  always_comb begin
    mapped = 1'b0;
    rdWord = bba_pkg::WORD_ZERO;
    if (inWin) begin
      mapped = 1'b1;
      rdWord[DW-1:0] = fileMem[winIdx];
    end else if (highZero) begin
      case (localAddr)
        bba_pkg::OFF_CTRL: begin
          mapped = 1'b1;
          rdWord[bba_pkg::CTRL_EXEC_BIT] = st_reg.execEn;
        end
        bba_pkg::OFF_ACC: begin
          mapped = 1'b1;
          rdWord[DW-1:0] = st_reg.acc;
        end
        bba_pkg::OFF_FLAGS: begin
          mapped = 1'b1;
          rdWord[bba_pkg::FLAG_CARRY_BIT] = st_reg.flags.carry;
          rdWord[bba_pkg::FLAG_NIBBLE_BIT] = st_reg.flags.nibbleRippleOut;
          rdWord[bba_pkg::FLAG_ZERO_BIT] = st_reg.flags.zero;
        end
        bba_pkg::OFF_STAT: begin
          mapped = 1'b1;
          rdWord[bba_pkg::STAT_SQUASH_BIT] = squashing;
          rdWord[bba_pkg::STAT_COUNT_LSB +: 16] = st_reg.opCount;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.opDone = 1'b0;
    memWe = 1'b0;
    memAddr = instr.fileAddr;
    memData = fileRd;

    if (fire) begin
      st_next.opDone = 1'b1;
      st_next.opCount = st_reg.opCount + bba_pkg::COUNT_ONE;
      case (instr.op)
        bba_pkg::SUM_IMMEDIATE_OP: begin
          st_next.acc = sumRes; // RQ1
          st_next.flags.carry = sumCarry; // RQ10
          st_next.flags.nibbleRippleOut = sumNibble; // RQ10
          st_next.flags.zero = (sumRes == bba_pkg::BYTE_ZERO); // RQ10
        end
        bba_pkg::SUM_REGISTER_OP: begin
          if (instr.destSel) begin
            memWe = 1'b1; // RQ2
            memData = sumRes;
          end else begin
            st_next.acc = sumRes; // RQ2
          end
          st_next.flags.carry = sumCarry; // RQ10
          st_next.flags.nibbleRippleOut = sumNibble; // RQ10
          st_next.flags.zero = (sumRes == bba_pkg::BYTE_ZERO); // RQ10
        end
        bba_pkg::MASK_IMMEDIATE_OP: begin
          st_next.acc = maskRes; // RQ3
          st_next.flags.zero = (maskRes == bba_pkg::BYTE_ZERO); // RQ3
        end
        bba_pkg::MASK_REGISTER_OP: begin
          if (instr.destSel) begin
            memWe = 1'b1; // RQ4
            memData = maskRes;
          end else begin
            st_next.acc = maskRes; // RQ4
          end
          st_next.flags.zero = (maskRes == bba_pkg::BYTE_ZERO); // RQ4
        end
        bba_pkg::BIT_CLEAR_OP: begin
          memWe = 1'b1;
          memData = fileRd & ~bitHot; // RQ5
        end
        bba_pkg::BIT_SET_OP: begin
          memWe = 1'b1;
          memData = fileRd | bitHot; // RQ6
        end
        bba_pkg::SKIP_IF_LOW_OP: begin
          if (!bitVal) begin
            st_next.state = bba_pkg::ST_SQUASH; // RQ7
          end
        end
        bba_pkg::SKIP_IF_HIGH_OP: begin
          if (bitVal) begin
            st_next.state = bba_pkg::ST_SQUASH; // RQ8
          end
        end
        default: begin
          st_next.opDone = 1'b0;
        end
      endcase
    end else if (accept) begin
      // discarded instruction runs as a no-operation
      st_next.state = bba_pkg::ST_RUN; // RQ9
    end

    if (apbCommit) begin
      if (inWin) begin
        memWe = 1'b1;
        memAddr = winIdx;
        memData = pwdata[DW-1:0];
      end else begin
        case (localAddr)
          bba_pkg::OFF_CTRL: begin
            st_next.execEn = pwdata[bba_pkg::CTRL_EXEC_BIT];
          end
          bba_pkg::OFF_ACC: begin
            st_next.acc = pwdata[DW-1:0];
          end
          bba_pkg::OFF_FLAGS: begin
            st_next.flags.carry = pwdata[bba_pkg::FLAG_CARRY_BIT];
            st_next.flags.nibbleRippleOut = pwdata[bba_pkg::FLAG_NIBBLE_BIT];
            st_next.flags.zero = pwdata[bba_pkg::FLAG_ZERO_BIT];
          end
          default: begin
            st_next.opCount = st_next.opCount;
          end
        endcase
      end
    end

    st_next.pready = apbAccess;
    st_next.pslverr = apbAccess & ~mapped;
    st_next.prdata = (apbAccess && mapped && !pwrite) ? rdWord : bba_pkg::WORD_ZERO;
    // decoder is held off while a bus access commits or execution is disabled
    st_next.opReady = ~apbAccess & st_next.execEn;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg.state <= bba_pkg::ST_RUN;
      st_reg.acc <= bba_pkg::ACC_RST;
      st_reg.flags <= '0;
      st_reg.execEn <= bba_pkg::CTRL_EXEC_RST;
      st_reg.opCount <= bba_pkg::COUNT_RST;
      st_reg.opReady <= 1'b0;
      st_reg.opDone <= 1'b0;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= bba_pkg::WORD_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (memWe) begin
      fileMem[memAddr] <= memData;
    end
  end

  assign opReady = st_reg.opReady;
  assign opDone = st_reg.opDone;
  assign accOut = st_reg.acc;
  assign statusOut = st_reg.flags;
  assign skipSquash = squashing;
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;

  // checks
  logic isSumI;
  logic isSumR;
  logic isMaskI;
  logic isMaskR;
  logic isBitWr;
  logic isSkipL;
  logic isSkipH;
  assign isSumI = fire & (instr.op == bba_pkg::SUM_IMMEDIATE_OP);
  assign isSumR = fire & (instr.op == bba_pkg::SUM_REGISTER_OP);
  assign isMaskI = fire & (instr.op == bba_pkg::MASK_IMMEDIATE_OP);
  assign isMaskR = fire & (instr.op == bba_pkg::MASK_REGISTER_OP);
  assign isBitWr = fire & ((instr.op == bba_pkg::BIT_CLEAR_OP) | (instr.op == bba_pkg::BIT_SET_OP));
  assign isSkipL = fire & (instr.op == bba_pkg::SKIP_IF_LOW_OP);
  assign isSkipH = fire & (instr.op == bba_pkg::SKIP_IF_HIGH_OP);

  a_sum_imm_acc: assert property (@(posedge clk) disable iff (srst) // RQ1
    isSumI |=> (accOut == $past(accOut + instr.literal)) && (statusOut.nibbleRippleOut == $past(sumNibble)))
    else $error("immediate sum result wrong");
  a_sum_reg_dest: assert property (@(posedge clk) disable iff (srst) // RQ2
    isSumR && instr.destSel |=> $stable(accOut) && (statusOut.carry == $past(sumCarry)))
    else $error("register sum disturbed accumulator");
  a_mask_imm_flags: assert property (@(posedge clk) disable iff (srst) // RQ3
    isMaskI |=> $stable(statusOut.carry) && $stable(statusOut.nibbleRippleOut) && (accOut == $past(maskRes)))
    else $error("immediate mask changed carry flags");
  a_mask_reg_zero: assert property (@(posedge clk) disable iff (srst) // RQ4
    isMaskR |=> (statusOut.zero == ($past(maskRes) == bba_pkg::BYTE_ZERO)) && $stable(statusOut.carry))
    else $error("register mask zero flag wrong");
  a_bit_write_quiet: assert property (@(posedge clk) disable iff (srst) // RQ5
    isBitWr |=> $stable(statusOut) && $stable(accOut))
    else $error("bit write touched flags or accumulator");
  a_bit_write_mem: assert property (@(posedge clk) disable iff (srst) // RQ6
    isBitWr |-> memWe && (memData[instr.bitSel] == (instr.op == bba_pkg::BIT_SET_OP)) &&
      ((memData ^ fileRd) == (bitHot & (fileRd ^ memData))))
    else $error("bit write changed other bits");
  a_skip_low_squash: assert property (@(posedge clk) disable iff (srst) // RQ7
    isSkipL |=> (skipSquash == !$past(bitVal)) && $stable(statusOut))
    else $error("skip-if-low squash wrong");
  a_skip_high_squash: assert property (@(posedge clk) disable iff (srst) // RQ8
    isSkipH |=> (skipSquash == $past(bitVal)) && $stable(statusOut))
    else $error("skip-if-high squash wrong");
  a_squash_one_slot: assert property (@(posedge clk) disable iff (srst) // RQ9
    skipSquash && accept |=> !skipSquash && !opDone && $stable(accOut))
    else $error("squash slot did not discard exactly one op");
  a_sum_carry_zero: assert property (@(posedge clk) disable iff (srst) // RQ10
    (isSumI || isSumR) |=> (statusOut.carry == $past(({1'b0, accOut} + {1'b0, addB}) >> bba_pkg::DATA_W)) &&
      (statusOut.zero == ($past(sumRes) == bba_pkg::BYTE_ZERO)))
    else $error("sum carry or zero flag wrong");
endmodule // bba_core

// *** hw/bba_pkg.sv ***
package bba_pkg;

  // datapath widths
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int FILE_ADDR_W = 7;
  localparam int BIT_SEL_W = 3;

  // register map, byte addresses on the 12-bit local window
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [2:0] FILE_WIN_SEL = 3'h1;
  localparam logic [19:0] HIGH_ADDR_ZERO = 20'h00000;

  // field positions
  localparam int CTRL_EXEC_BIT = 0;
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_NIBBLE_BIT = 1;
  localparam int FLAG_ZERO_BIT = 2;
  localparam int STAT_SQUASH_BIT = 0;
  localparam int STAT_COUNT_LSB = 16;

  // reset values and other constants
  localparam logic CTRL_EXEC_RST = 1'b1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // operation codes from the decoder
  typedef enum logic [2:0] {
    SUM_IMMEDIATE_OP = 3'h0,
    SUM_REGISTER_OP = 3'h1,
    MASK_IMMEDIATE_OP = 3'h2,
    MASK_REGISTER_OP = 3'h3,
    BIT_CLEAR_OP = 3'h4,
    BIT_SET_OP = 3'h5,
    SKIP_IF_LOW_OP = 3'h6,
    SKIP_IF_HIGH_OP = 3'h7
  } bba_op_e;

  // sequencing states
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_SQUASH = 2'h2
  } bba_state_e;

  // one instruction as handed over by the decoder
  typedef struct packed {
    bba_op_e op;
    logic [FILE_ADDR_W-1:0] fileAddr;
    logic [BIT_SEL_W-1:0] bitSel;
    logic destSel;
    logic [DATA_W-1:0] literal;
  } bba_instr_s;

  typedef struct packed {
    logic zero;
    logic nibbleRippleOut;
    logic carry;
  } bba_flags_s;

  typedef struct packed {
    bba_state_e state;
    logic [DATA_W-1:0] acc;
    bba_flags_s flags;
    logic execEn;
    logic [15:0] opCount;
    logic opReady;
    logic opDone;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bba_core_state_s;

endpackage

// *** hw/bba_adder.sv ***
`timescale 1ns/1ps
module bba_adder #(
  parameter int W = 8,
  parameter int NIB = 4
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] sum,
  output logic carryOut,
  output logic nibbleOut
);
  logic [W:0] full;
  logic [NIB:0] low;

  if (NIB < 1 || NIB >= W) begin : g_nib_check
    $error("bba_adder: nibble width out of range");
  end

  // carry out of the top bit and out of the low nibble
  assign full = {1'b0, a} + {1'b0, b}; // RQ10
  assign low = {1'b0, a[NIB-1:0]} + {1'b0, b[NIB-1:0]}; // RQ10
  assign sum = full[W-1:0];
  assign carryOut = full[W];
  assign nibbleOut = low[NIB];
endmodule // bba_adder

// *** hw/bba_bitmask.sv ***
`timescale 1ns/1ps
module bba_bitmask #(
  parameter int W = 8,
  parameter int SEL_W = 3
) (
  input wire logic [SEL_W-1:0] sel,
  output logic [W-1:0] mask
);
  if (W > (1 << SEL_W)) begin : g_sel_check
    $error("bba_bitmask: select too narrow for width");
  end

  // one-hot mask of the selected bit position
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign mask[i] = (sel == SEL_W'(i));
  end
endmodule // bba_bitmask

// *** sim/bba_feeder.sv ***
`timescale 1ns/1ps
module bba_feeder (
  input wire logic clk,
  input wire logic opReady,
  output logic opValid,
  output bba_pkg::bba_instr_s instr
);
  initial begin
    opValid = 1'b0;
    instr = '0;
  end
  // optional idle gap, then present one op and hold it until the edge that takes it
  task automatic issue(input bba_pkg::bba_instr_s i, input int gap);
    repeat (gap) @(posedge clk);
    opValid <= 1'b1;
    instr <= i;
    do @(posedge clk); while (opReady !== 1'b1);
  endtask
  // drop the request; every field of the held instruction is inverted so stale data is not presented again
  task automatic stop();
    opValid <= 1'b0;
    instr <= bba_pkg::bba_instr_s'(~instr);
  endtask
endmodule // bba_feeder

// *** sim/byte_and_bit_alu_ops_tb.sv ***
`timescale 1ns/1ps
module byte_and_bit_alu_ops_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic opValid, opReady, opDone, skipSquash, pready, pslverr, err;
  logic [7:0] accOut;
  bba_pkg::bba_instr_s instr;
  bba_pkg::bba_flags_s statusOut;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int opCnt = 0;
  always #5 clk = ~clk;
  bba_core DUT (.clk(clk), .srst(srst), .opValid(opValid), .instr(instr), .opReady(opReady), .opDone(opDone),
    .accOut(accOut), .statusOut(statusOut), .skipSquash(skipSquash), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bba_feeder FEED (.clk(clk), .opReady(opReady), .opValid(opValid), .instr(instr));
  function automatic bba_pkg::bba_instr_s mk(bba_pkg::bba_op_e o, logic [6:0] a, logic [2:0] b, logic d,
    logic [7:0] k);
    mk = '{op: o, fileAddr: a, bitSel: b, destSel: d, literal: k};
  endfunction
  function automatic logic [11:0] fa(logic [6:0] n);
    fa = 12'h200 + {3'h0, n, 2'h0};
  endfunction
  // upper three bits zero, nibble carry, carry; low byte the sum
  function automatic logic [10:0] addExp(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    addExp = {s[7:0] == 8'h00, ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8], s[7:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {20'h00000, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op1(input bba_pkg::bba_instr_s i, input logic done);
    FEED.issue(i, opCnt % 2);
    FEED.stop();
    #1;
    chk("opDone", opDone, done);
    if (done) opCnt++;
    @(posedge clk);
  endtask
  task automatic test_reset();
    chk("accRst", accOut, 32'h00000000);
    chk("flagRst", statusOut, 32'h00000000);
    chk("squashRst", skipSquash, 32'h00000000);
    apb(1'b0, bba_pkg::OFF_CTRL, 32'h00000000);
    chk("ctrlRst", rd, 32'h00000001);
    apb(1'b0, 12'h010, 32'h00000000);
    chk("unmappedErr", err, 32'h00000001);
    chk("unmappedData", rd, 32'h00000000);
  endtask
  task automatic test_sum_imm();
    logic [7:0] av [5] = '{8'hFF, 8'h0F, 8'h80, 8'h12, 8'h08};
    logic [7:0] kv [5] = '{8'h01, 8'h01, 8'h80, 8'h34, 8'h08};
    logic [10:0] e;
    for (int j = 0; j < 5; j++) begin
      e = addExp(av[j], kv[j]);
      apb(1'b1, bba_pkg::OFF_ACC, {24'h000000, av[j]});
      op1(mk(bba_pkg::SUM_IMMEDIATE_OP, 7'h00, 3'h0, 1'b0, kv[j]), 1'b1);
      chk("sumImmAcc", accOut, e[7:0]);
      chk("sumImmFlags", statusOut, e[10:8]);
    end
  endtask
  task automatic test_sum_reg();
    logic [10:0] e;
    logic [6:0] n;
    for (int d = 0; d < 2; d++) begin
      n = d[0] ? 7'h00 : 7'h7F;
      e = addExp(8'h03, 8'hFE + d[7:0]);
      apb(1'b1, bba_pkg::OFF_ACC, 32'h00000003);
      apb(1'b1, fa(n), 32'h000000FE + d);
      op1(mk(bba_pkg::SUM_REGISTER_OP, n, 3'h0, d[0], 8'h00), 1'b1);
      chk("sumRegAcc", accOut, d[0] ? 8'h03 : e[7:0]);
      chk("sumRegFlags", statusOut, e[10:8]);
      apb(1'b0, fa(n), 32'h00000000);
      chk("sumRegFile", rd, d[0] ? e[7:0] : 8'hFE);
    end
  endtask
  task automatic test_mask();
    apb(1'b1, bba_pkg::OFF_FLAGS, 32'h00000003);
    apb(1'b1, bba_pkg::OFF_ACC, 32'h000000F0);
    op1(mk(bba_pkg::MASK_IMMEDIATE_OP, 7'h00, 3'h0, 1'b0, 8'h0F), 1'b1);
    chk("maskImmAcc", accOut, 32'h00000000);
    chk("maskImmFlags", statusOut, 32'h00000007);
    apb(1'b1, bba_pkg::OFF_ACC, 32'h000000F0);
    apb(1'b1, fa(7'h05), 32'h0000003C);
    op1(mk(bba_pkg::MASK_REGISTER_OP, 7'h05, 3'h0, 1'b1, 8'h00), 1'b1);
    chk("maskRegAcc", accOut, 32'h000000F0);
    chk("maskRegFlags", statusOut, 32'h00000003);
    apb(1'b0, fa(7'h05), 32'h00000000);
    chk("maskRegFile", rd, 32'h00000030);
    apb(1'b1, fa(7'h05), 32'h0000000F);
    op1(mk(bba_pkg::MASK_REGISTER_OP, 7'h05, 3'h0, 1'b0, 8'h00), 1'b1);
    chk("maskAccDest", accOut, 32'h00000000);
    chk("maskAccFlags", statusOut, 32'h00000007);
  endtask
  task automatic test_bits();
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, bba_pkg::OFF_FLAGS, 32'h00000005);
      apb(1'b1, fa(7'h7F), 32'h000000FF);
      op1(mk(bba_pkg::BIT_CLEAR_OP, 7'h7F, b[2:0], 1'b0, 8'h00), 1'b1);
      apb(1'b0, fa(7'h7F), 32'h00000000);
      chk("bitClear", rd, 8'hFF & ~(8'h01 << b));
      apb(1'b1, fa(7'h7F), 32'h00000000);
      op1(mk(bba_pkg::BIT_SET_OP, 7'h7F, b[2:0], 1'b0, 8'h00), 1'b1);
      apb(1'b0, fa(7'h7F), 32'h00000000);
      chk("bitSet", rd, 8'h01 << b);
      chk("bitFlags", statusOut, 32'h00000005);
    end
  endtask
  task automatic test_skip();
    logic sk;
    for (int j = 0; j < 4; j++) begin
      sk = (j < 2) ? (j == 0) : (j == 3);
      apb(1'b1, fa(7'h14), j[0] ? 32'h00000080 : 32'h0000007F);
      apb(1'b1, bba_pkg::OFF_FLAGS, 32'h00000002);
      apb(1'b1, bba_pkg::OFF_ACC, 32'h00000010);
      FEED.issue(mk(j < 2 ? bba_pkg::SKIP_IF_LOW_OP : bba_pkg::SKIP_IF_HIGH_OP, 7'h14, 3'h7, 1'b0, 8'h00), 0);
      FEED.issue(mk(bba_pkg::SUM_IMMEDIATE_OP, 7'h00, 3'h0, 1'b0, 8'h01), 0);
      chk("squashFlag", skipSquash, sk);
      FEED.stop();
      #1;
      chk("squashDone", opDone, !sk);
      chk("skipAcc", accOut, sk ? 8'h10 : 8'h11);
      chk("skipFlags", statusOut, sk ? 3'h2 : 3'h0);
      chk("squashClear", skipSquash, 32'h00000000);
      opCnt += sk ? 1 : 2;
      @(posedge clk);
    end
  endtask
  task automatic test_exec();
    apb(1'b1, bba_pkg::OFF_CTRL, 32'h00000000);
    apb(1'b0, bba_pkg::OFF_STAT, 32'h00000000);
    chk("execGate", opReady, 32'h00000000);
    chk("opCount", rd[31:16], opCnt[15:0]);
    apb(1'b1, bba_pkg::OFF_CTRL, 32'h00000001);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_sum_imm();
    test_sum_reg();
    test_mask();
    test_bits();
    test_skip();
    test_exec();
    complete_run();
  end
  // cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
endmodule // byte_and_bit_alu_ops_tb
